/* pkg/iqtx_defs.svh */
// Constants for the IQ antenna-carrier transmit port: widths, depths,
// status field positions and reset values.
// Assumes it is included by its bare name wherever these are needed.
`ifndef IQTX_DEFS_SVH
`define IQTX_DEFS_SVH

`define IQTX_DATA_W        32
`define IQTX_HALF_W        16
`define IQTX_FIFO_DEPTH    8
`define IQTX_CNT_W         4
`define IQTX_THR_W         4
`define IQTX_THR_RESET     4'h4

`define IQTX_STAT_W        3
`define IQTX_STAT_OVF_BIT  2
`define IQTX_STAT_UNF_BIT  1
`define IQTX_STAT_EN_BIT   0
`define IQTX_STAT_RESET    3'h0
`define IQTX_CTRL_RESET    1'h0

`define IQTX_SYNC_W        36

`endif

/* pkg/iqtx_pkg.sv */
// Types shared by the IQ transmit port modules.
// Assumes iqtx_defs.svh is on the include path.
`include "iqtx_defs.svh"

package iqtx_pkg;

  typedef enum logic [1:0] {
    IQTX_MODE_FIFO,
    IQTX_MODE_SYNC_BUF,
    IQTX_MODE_INT_CLK
  } iqtx_mode_t;

  // Quadrature in the high half, in-phase in the low half
  typedef struct packed {
    logic [`IQTX_HALF_W-1:0] q;
    logic [`IQTX_HALF_W-1:0] i;
  } iqtx_sample_t;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic enabled;
  } iqtx_status_t;

  // Channel pins as they cross into the core clock domain
  typedef struct packed {
    logic         clk;
    logic         rst;
    logic         valid;
    logic         resync;
    iqtx_sample_t data;
  } iqtx_pins_t;

endpackage

/* rtl/iqtx_fifo.sv */
// Synchronous FIFO with valid/ready on both sides, flush and fill count.
// Assumes one clock; a refused write or read leaves the contents intact.
`timescale 1ns/1ps
`default_nettype none

module iqtx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input  wire logic             mclk,      // core clock
  input  wire logic             reset,     // synchronous, active high
  input  wire logic             flush,     // empty the buffer
  input  wire logic             in_valid,  // write request
  output var  logic             in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word to write
  output var  logic             out_valid, // a word is waiting
  input  wire logic             out_ready, // consumer takes the word
  output var  logic [WIDTH-1:0] out_data,  // head word
  output var  logic [CNT_W-1:0] count      // words held
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire              push;
  wire              pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready  = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign count     = count_reg;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

endmodule

`default_nettype wire

/* rtl/iqtx_port.sv */
// Transmit port of one antenna-carrier channel: takes IQ words from the
// application, buffers them and hands them to the core framing logic.
// Assumes the framing logic runs on mclk; the channel pins, clock included,
// are asynchronous and are sampled here, the channel clock much slower.
//
// Contract
// - Mode from build parameter and config input
// - Channel clock drives port; core clock internally
// - Valid sampled at edges, data at the edge after valid high
// - In-phase low half, quadrature high half
// - FIFO ready while fill below shared threshold
// - FIFO mode handshake_ready_delay is zero
// - Internal clock: ready one cycle early
// - Resync used in sync buffer mode only
// - Sticky overflow on write to full buffer
// - Sticky underflow on read from empty buffer
// - Enabled bit taken from control register
`timescale 1ns/1ps
`default_nettype none

module iqtx_port
  import iqtx_pkg::*;
#(
  parameter bit INT_CLK_BUILD = 1'b0
) (
  input  wire logic                     mclk,             // core clock, 100 MHz
  input  wire logic                     reset,            // synchronous, active high
  input  wire logic                     ch_clk,           // channel clock pin
  input  wire logic                     ch_reset,         // channel reset pin, active high
  input  wire logic                     ch_valid,         // write-valid from application
  input  wire logic [`IQTX_DATA_W-1:0]  ch_data,          // IQ word from application
  input  wire logic                     ch_resync,        // resynchronisation pin
  output var  logic                     ch_ready,         // buffer can take data
  input  wire logic                     cfg_sync_buffer,  // 1 selects synchronous buffer mode
  input  wire logic [`IQTX_THR_W-1:0]   ready_thr,        // shared ready threshold
  input  wire logic                     ctrl_enable,      // channel enable control bit
  input  wire logic                     status_clear,     // clears sticky error bits
  input  wire logic                     frame_rd_req,     // framing logic wants a word
  output var  logic [`IQTX_DATA_W-1:0]  frame_data,       // word for the frame
  output var  logic                     frame_data_valid, // frame_data updated this cycle
  output var  iqtx_status_t             status_data       // overflow, underflow, enabled
);

  // Mode selection and input path

  iqtx_mode_t   mode;
  iqtx_pins_t   pins_raw;
  iqtx_pins_t   pins_sync;
  iqtx_pins_t   pins;
  logic         clk_prev_reg;
  wire          int_clk;
  wire          ch_tick;
  wire          ch_rst;

  assign mode = INT_CLK_BUILD   ? IQTX_MODE_INT_CLK :
                cfg_sync_buffer ? IQTX_MODE_SYNC_BUF : IQTX_MODE_FIFO;
  assign int_clk = (mode == IQTX_MODE_INT_CLK);

  assign pins_raw.clk    = ch_clk;
  assign pins_raw.rst    = ch_reset;
  assign pins_raw.valid  = ch_valid;
  assign pins_raw.resync = ch_resync;
  assign pins_raw.data   = iqtx_sample_t'(ch_data);

  iqtx_sync #(
    .WIDTH (`IQTX_SYNC_W)
  ) u_pin_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= pins_sync.clk;
    end
  end

  // channel clock edge or core clock
  assign pins    = int_clk ? pins_raw : pins_sync;
  assign ch_tick = int_clk ? 1'b1 : (pins_sync.clk & ~clk_prev_reg);

  // channel reset, unused when clocked internally
  assign ch_rst = ~int_clk & pins.rst;

  // Control register

  logic         tx_buffer_control_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_buffer_control_reg <= `IQTX_CTRL_RESET;
    end else begin
      tx_buffer_control_reg <= ctrl_enable;
    end
  end

  // Write side

  logic         pend_reg;
  wire          resync_hit;
  wire          wr_attempt;
  wire          flush;
  wire          fifo_in_ready;
  wire          ovf_event;

  // resync only counts in synchronous buffer mode
  assign resync_hit = ch_tick & pins.resync & (mode == IQTX_MODE_SYNC_BUF);

  // valid captured at a channel edge
  // resync and valid together: flush first, word lands after it
  always_ff @(posedge mclk) begin
    if (reset || ch_rst) begin
      pend_reg <= 1'b0;
    end else if (ch_tick) begin
      pend_reg <= pins.valid;
    end
  end

  // data taken one channel cycle after valid
  assign wr_attempt = ch_tick & pend_reg & tx_buffer_control_reg;

  // Disabling the channel drops what it held so stale samples never
  // reach a frame after re-enable
  assign flush = ch_rst | resync_hit | ~tx_buffer_control_reg;

  // overflow when the buffer refuses a word
  assign ovf_event = wr_attempt & ~fifo_in_ready;

  // Buffer

  logic [`IQTX_CNT_W-1:0]  fill;
  logic                    fifo_out_valid;
  logic [`IQTX_DATA_W-1:0] fifo_out_data;
  wire                     rd_take;
  wire                     unf_event;

  assign rd_take = frame_rd_req & tx_buffer_control_reg;

  iqtx_fifo #(
    .WIDTH (`IQTX_DATA_W),
    .DEPTH (`IQTX_FIFO_DEPTH),
    .CNT_W (`IQTX_CNT_W)
  ) u_buf (
    .mclk      (mclk),
    .reset     (reset),
    .flush     (flush),
    .in_valid  (wr_attempt),
    .in_ready  (fifo_in_ready),
    .in_data   (pins.data),
    .out_valid (fifo_out_valid),
    .out_ready (rd_take),
    .out_data  (fifo_out_data),
    .count     (fill)
  );

  // underflow on read of empty buffer
  assign unf_event = rd_take & ~fifo_out_valid;

  // Read side toward the framing logic

  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_data       <= '0;
      frame_data_valid <= 1'b0;
    end else begin
      frame_data_valid <= rd_take & fifo_out_valid;
      if (rd_take && fifo_out_valid) begin
        frame_data <= fifo_out_data;
      end
    end
  end

  // Ready

  logic         ready_next;
  wire          below_thr;

  assign below_thr = (fill < ready_thr);

  // FIFO mode: a word sampled while ready is high is taken if ready_thr is below the depth
  // internal clock: the same flag, read one cycle ahead
  // ready held low in synchronous buffer mode
  always_comb begin
    ready_next = 1'b0;
    unique case (mode)
      IQTX_MODE_FIFO:     ready_next = below_thr & tx_buffer_control_reg & ~ch_rst;
      IQTX_MODE_INT_CLK:  ready_next = below_thr & tx_buffer_control_reg;
      IQTX_MODE_SYNC_BUF: ready_next = 1'b0;
    endcase
  end

  // application waits for ready before valid
  // application waits one cycle after ready
  always_ff @(posedge mclk) begin
    if (reset) begin
      ch_ready <= 1'b0;
    end else begin
      ch_ready <= ready_next;
    end
  end

  // Status register

  iqtx_status_t tx_buffer_status_reg;

  // sticky overflow, set wins over clear
  // sticky underflow, set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_buffer_status_reg <= `IQTX_STAT_RESET;
    end else begin
      tx_buffer_status_reg.overflow  <= ovf_event | (tx_buffer_status_reg.overflow & ~status_clear);
      tx_buffer_status_reg.underflow <= unf_event | (tx_buffer_status_reg.underflow & ~status_clear);
      tx_buffer_status_reg.enabled   <= tx_buffer_control_reg;
    end
  end

  assign status_data = tx_buffer_status_reg;

endmodule

`default_nettype wire

/* rtl/iqtx_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a level that stays put for several clock cycles.
`timescale 1ns/1ps
`default_nettype none

module iqtx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,    // core clock
  input  wire logic             reset,   // synchronous, active high
  input  wire logic [WIDTH-1:0] async_in, // levels from outside
  output var  logic [WIDTH-1:0] sync_out  // resynchronised levels
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* testbench/iqtx_app_model.sv */
// Application-side model: makes the channel clock and streams IQ words.
// Assumes the port samples its channel pins with mclk.
`timescale 1ns/1ps
`default_nettype none
module iqtx_app_model (
  input  wire logic        go,        // stream words
  input  wire logic        sync_mode, // sync-buffer mode
  input  wire logic        ch_ready,  // port ready
  input  wire logic        rst_req,   // channel reset wanted
  output var  logic        ch_reset,  // channel reset
  output var  logic        ch_clk,    // channel clock
  output var  logic        ch_valid,  // write-valid
  output var  logic [31:0] ch_data,   // IQ word
  output var  logic        ch_resync, // resync
  output var  int          sent       // words handed over
);
  initial begin
    ch_clk = 1'b0;
    ch_valid = 1'b0;
    ch_data = 32'h0;
    ch_resync = 1'b0;
    ch_reset = 1'b0;
    sent = 0;
  end
  always #40 ch_clk = ~ch_clk;
  always @(posedge ch_clk) begin
    if (ch_valid) begin
      ch_data <= {16'(sent) ^ 16'h0a5a, ~16'(sent)};
      sent <= sent + 1;
    end else begin
      // Inverted so stale data never passes for a word
      ch_data <= ~ch_data;
    end
    ch_valid <= go && (sync_mode || ch_ready);
    ch_resync <= go && sync_mode && !ch_valid;
    ch_reset <= rst_req;
  end
endmodule
`default_nettype wire

/* testbench/iqtx_port_checker.sv */
// Concurrent checks on the transmit port's top-level ports.
// Assumes one mclk domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module iqtx_port_checker
  import iqtx_pkg::*;
#(
  parameter bit INT_CLK_BUILD = 1'b0
) (
  input wire logic         mclk,             // clock
  input wire logic         reset,            // reset
  input wire logic         ch_ready,         // ready
  input wire logic         cfg_sync_buffer,  // mode
  input wire logic [3:0]   ready_thr,        // threshold
  input wire logic         ctrl_enable,      // enable
  input wire logic         status_clear,     // clear
  input wire logic         frame_rd_req,     // read
  input wire logic         frame_data_valid, // read answer
  input wire iqtx_status_t status_data       // status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  rst_quiet_a: assert property ($past(reset) |-> status_data == 3'h0 && !ch_ready && !frame_data_valid)
    else $error("outputs not idle after reset");
  en_rise_a: assert property ($rose(ctrl_enable) |-> ##2 status_data.enabled)
    else $error("enabled bit late");
  ovf_hold_a: assert property (status_data.overflow && !status_clear |=> status_data.overflow)
    else $error("overflow lost");
  unf_cause_a: assert property ($rose(status_data.underflow) |-> $past(frame_rd_req) || $past(frame_rd_req, 2))
    else $error("underflow without read");
  rd_answer_a: assert property (frame_rd_req && $past(ctrl_enable) && !$past(reset)
    |=> frame_data_valid || status_data.underflow)
    else $error("read not answered");
  rd_cause_a: assert property (frame_data_valid |-> $past(frame_rd_req))
    else $error("word without read");
  thr_zero_a: assert property (ready_thr == 4'h0 ##1 ready_thr == 4'h0 |=> !ch_ready)
    else $error("ready at zero threshold");
  sync_quiet_a: assert property (!INT_CLK_BUILD && cfg_sync_buffer ##1 cfg_sync_buffer |=> !ch_ready)
    else $error("ready in sync mode");

  cover property (frame_data_valid && cfg_sync_buffer);
  cover property ($rose(status_data.overflow));
  cover property ($rose(status_data.underflow));
endmodule

bind iqtx_port iqtx_port_checker #(.INT_CLK_BUILD(INT_CLK_BUILD)) chk (.mclk, .reset, .ch_ready, .cfg_sync_buffer,
  .ready_thr, .ctrl_enable, .status_clear, .frame_rd_req, .frame_data_valid, .status_data);
`default_nettype wire

/* testbench/iqtx_port_test.sv */
// Self-checking bench for the transmit port in all three modes.
// Assumes the application model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module iqtx_port_test;
  import iqtx_pkg::*;
  logic         mclk = 1'b0, reset = 1'b1, cfg_sync_buffer = 1'b0, ctrl_enable = 1'b0;
  logic         status_clear = 1'b0, frame_rd_req = 1'b0, go = 1'b0, ch_rst_req = 1'b0, i_go = 1'b0;
  logic         ch_reset, i_valid = 1'b0, i_ready, i_fvalid;
  logic [31:0]  i_data = 32'h0, i_fdata;
  iqtx_status_t i_status;
  logic         ch_ready, ch_clk, ch_valid, ch_resync, frame_data_valid;
  logic [31:0]  ch_data, frame_data;
  logic [3:0]   ready_thr = 4'h4;
  iqtx_status_t status_data;
  int           error_cnt = 0, total_checks = 0, got = 0, sent, got_int = 0, i_sent = 0;
  logic [31:0]  seed = 32'h0000cd41;

  always #5 mclk = ~mclk;
  iqtx_port #(.INT_CLK_BUILD(1'b0)) uut (.mclk, .reset, .ch_clk, .ch_reset, .ch_valid, .ch_data,
    .ch_resync, .ch_ready, .cfg_sync_buffer, .ready_thr, .ctrl_enable, .status_clear, .frame_rd_req,
    .frame_data, .frame_data_valid, .status_data);
  iqtx_app_model app (.go, .sync_mode(cfg_sync_buffer), .ch_ready, .rst_req(ch_rst_req), .ch_reset, .ch_clk,
    .ch_valid, .ch_data, .ch_resync, .sent);
  iqtx_port #(.INT_CLK_BUILD(1'b1)) uut_int (.mclk, .reset, .ch_clk(1'b0), .ch_reset(1'b0), .ch_valid(i_valid),
    .ch_data(i_data), .ch_resync(1'b0), .ch_ready(i_ready), .cfg_sync_buffer, .ready_thr, .ctrl_enable,
    .status_clear, .frame_rd_req, .frame_data(i_fdata), .frame_data_valid(i_fvalid), .status_data(i_status));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic iqtx_sample_t exp_word(int n);
    exp_word.q = 16'(n) ^ 16'h0a5a;
    exp_word.i = ~16'(n);
  endfunction
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  // Reads with chance m in 4 each cycle
  task automatic run(input int n, input int m);
    repeat (n) begin
      @(posedge mclk);
      frame_rd_req <= (rnd() % 4) < m;
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(negedge mclk) begin
    if (!reset && frame_data_valid === 1'b1) begin
      cmp_word(frame_data, exp_word(got));
      got++;
    end
    if (!reset && i_fvalid === 1'b1) begin
      cmp_word(i_fdata, exp_word(got_int));
      got_int++;
    end
  end

  // valid a cycle after ready, word a cycle after valid
  always @(posedge mclk) begin
    if (i_valid) begin
      i_data <= exp_word(i_sent);
      i_sent <= i_sent + 1;
    end else begin
      i_data <= ~i_data;
    end
    i_valid <= i_go && i_ready === 1'b1;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out;
  end

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    ctrl_enable <= 1'b1;
    ready_thr <= 4'h0;
    run(1, 0);
    #1 cmp_word(32'(status_data), 32'h0);
    run(3, 0);
    #1 cmp_bit(status_data.enabled, 1'b1);
    cmp_bit(ch_ready, 1'b0);
    run(1, 4);
    run(3, 0);
    status_clear <= 1'b1;
    #1 cmp_bit(status_data.underflow, 1'b1);
    run(2, 0);
    status_clear <= 1'b0;
    run(1, 0);
    go <= 1'b1;
    #1 cmp_bit(status_data.underflow, 1'b0);
    // Threshold kept below depth: ready overshoots by one word
    repeat (4) begin
      ready_thr <= 4'(1 + rnd() % 7);
      run(800, 1);
    end
    go <= 1'b0;
    run(300, 4);
    cfg_sync_buffer <= 1'b1;
    #1 cmp_word(32'(got), 32'(sent));
    run(20, 4);
    go <= 1'b1;
    run(1500, 4);
    go <= 1'b0;
    #1 cmp_bit(ch_ready, 1'b0);
    run(300, 4);
    cfg_sync_buffer <= 1'b0;
    ready_thr <= 4'h8;
    go <= 1'b1;
    #1 cmp_word(32'(got), 32'(sent));
    run(600, 0);
    go <= 1'b0;
    #1 cmp_bit(status_data.overflow, 1'b1);
    cmp_bit(ch_ready, 1'b0);
    // Channel reset empties the full buffer; ready stays low until release
    run(40, 0);
    ch_rst_req <= 1'b1;
    run(24, 0);
    ch_rst_req <= 1'b0;
    #1 cmp_bit(ch_ready, 1'b0);
    run(24, 0);
    ready_thr <= 4'(1 + rnd() % 5);
    i_go <= 1'b1;
    #1 cmp_bit(ch_ready, 1'b1);
    // Internal clock: ready lag allows at most three extra words, so no overflow
    run(300, 0);
    i_go <= 1'b0;
    #1 cmp_bit(i_status.overflow, 1'b0);
    cmp_bit(i_ready, 1'b0);
    run(300, 4);
    ctrl_enable <= 1'b0;
    #1 cmp_word(32'(got_int), 32'(i_sent));
    run(4, 0);
    status_clear <= 1'b1;
    #1 cmp_bit(status_data.enabled, 1'b0);
    run(2, 0);
    #1 cmp_bit(status_data.overflow, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
